// [tb.sv]
// Self-checking bench of the timer/capture/compare unit
`timescale 1ns/1ps
`include "tccu_consts.vh"
`define TB_CHK(nm, e, g) begin \
    comparisons++; \
    if ((g) !== (e)) begin \
        n_fail++; \
        $display("Error %s expected %h seen %h", nm, e, g); \
    end \
end
module tb;
    // ------------
    // Signals, model and counters
    // ------------
    localparam logic [7:0] A_FLG = `TCCU_ADR_PERIPHERAL_FLAGS;
    localparam logic [7:0] A_WL = `TCCU_ADR_WIDE_LOW;
    localparam logic [7:0] A_WH = `TCCU_ADR_WIDE_HIGH;
    localparam logic [7:0] A_WC = `TCCU_ADR_WIDE_CONTROL;
    localparam logic [7:0] A_CNT = `TCCU_ADR_PERIOD_COUNT;
    localparam logic [7:0] A_PTC = `TCCU_ADR_PERIOD_CONTROL;
    localparam logic [7:0] A_CL = `TCCU_ADR_CAPTURE_LOW;
    localparam logic [7:0] A_CH = `TCCU_ADR_CAPTURE_HIGH;
    localparam logic [7:0] A_CCP = `TCCU_ADR_CCP_CONTROL;
    localparam logic [7:0] A_LIM = `TCCU_ADR_PERIOD_LIMIT;
    logic       clk_i = 1'b0;     // 250 MHz clock
    logic       nrst_i = 1'b0;    // Reset, active low
    logic       por_i = 1'b1;     // Reset kind
    logic       wr_i = 1'b0;      // Write strobe
    logic       rd_i = 1'b0;      // Read strobe
    logic       dir_in = 1'b1;    // Port direction, 1 = input
    logic [7:0] addr_i = 8'h00;   // Address
    logic [7:0] wdata_i = 8'h00;  // Write data
    wire  [7:0] rdata_o;          // Read data
    wire        pin_q;            // Output latch
    wire        oe_n;             // Low while the unit drives
    wire        match_w;          // Period match pulse
    wire        src_pin;          // Level from the far side
    wire        pin_w = oe_n ? src_pin : pin_q; // Resolved pin
    logic [7:0] mr [int];         // Register model
    logic [7:0] last, lim;        // Last read, period limit
    logic [15:0] v;               // Random 16-bit value
    logic [7:0] ra [10] = '{A_FLG, A_WL, A_WH, A_WC, A_CNT, A_PTC,
                            A_CCP, 8'h8C, A_LIM, 8'h20};
    int cm [5] = '{8, 10, 9, 11, 8};  // Compare modes
    int cp [5] = '{1, 1, 0, 0, 1};    // Pin after each
    int ne [4] = '{1, 1, 4, 16};      // Edges per capture
    int n_fail = 0, comparisons = 0, cyc = 0, tm = 0, tp = 0;
    int post, dv;
    integer seed = 32'h1ed3;

    tccu_top dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .por_i(por_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .ccp_pin_i(pin_w), .ccp_pin_o(pin_q),
        .port_dir_in_i(dir_in), .ccp_pin_oe_n_o(oe_n),
        .period_match_o(match_w), .special_trig_o());
    tccu_pin_src src_u (.clk_i(clk_i), .pin_o(src_pin));

    // Clock and hang guard
    always #2 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            wrap_up();
        end
    end

    // ------------
    // Bus tasks and helpers
    // ------------
    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        case (a)
            A_WC, A_CCP: mr[a] = d & `TCCU_MASK_CCP_CONTROL;
            A_PTC: mr[a] = d & `TCCU_MASK_PERIOD_CONTROL;
            A_FLG: mr[a] = d & `TCCU_MASK_FLAGS;
            default: mr[a] = d;
        endcase
    endtask
    task automatic rc(input logic [7:0] a);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        last = rdata_o;
        if (mr.exists(a))
            `TB_CHK($sformatf("reg %h", a), mr[a], rdata_o)
    endtask
    task automatic rst(input logic p);
        @(posedge clk_i);
        por_i <= p;
        nrst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        nrst_i <= 1'b1;
        if (p)
            mr[A_WC] = 8'h00;
        foreach (ra[i])
            if (ra[i] != A_WL && ra[i] != A_WH && ra[i] != A_WC)
                mr[ra[i]] = (ra[i] == A_LIM) ? 8'hFF : 8'h00;
    endtask
    task automatic wait_match();
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            #1;
            n++;
        end while (!match_w && n < 3000);
        tp = tm;
        tm = cyc;
    endtask

    // ------------
    // Main sequence
    // ------------
    initial begin
        rst(1'b1);
        wr(A_WL, 8'($random(seed)));
        wr(A_WH, 8'($random(seed)));
        wr(8'h0B, 8'($random(seed)));
        rc(8'h0B);
        foreach (ra[i]) rc(ra[i]);
        wr(A_WC, 8'($random(seed)) & 8'h3E);
        wr(A_PTC, 8'h7F);
        rst(1'b0);
        foreach (ra[i]) rc(ra[i]);
        rst(1'b1);
        foreach (ra[i]) rc(ra[i]);
        // Period timer over every prescale code
        for (int ps = 0; ps < 4; ps++) begin
            lim = 8'd3 + 8'({$random(seed)} % 6);
            post = {$random(seed)} % 3;
            dv = (ps == 0) ? 1 : (ps == 1) ? 4 : 16;
            wr(A_LIM, lim);
            wr(A_CNT, 8'h00);
            wr(A_FLG, 8'h00);
            wr(A_PTC, 8'(post * 8 + 4 + ps));
            for (int k = 0; k < post + 2; k++) begin
                wait_match();
                if (k > 0) `TB_CHK("period", (lim + 1) * dv, tm - tp)
                mr[A_FLG] = (k >= post) ? 8'h02 : 8'h00;
                rc(A_FLG);
            end
            wr(A_PTC, 8'h00);
        end
        mr.delete(A_CNT);
        rc(A_CNT);
        mr[A_CNT] = last;
        wr(A_PTC, 8'h7B);
        rc(A_CNT);
        wr(A_CNT, 8'($random(seed)));
        rc(A_CNT);
        // Compare actions with the unit driving the pin
        @(posedge clk_i);
        dir_in <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            v = 16'($random(seed));
            wr(A_CH, ~v[15:8]);
            wr(A_WL, v[7:0]);
            wr(A_WH, v[15:8]);
            wr(A_FLG, 8'h00);
            wr(A_CCP, 8'(cm[i]));
            wr(A_CL, v[7:0]);
            wr(A_CH, v[15:8]);
            repeat (3) @(posedge clk_i);
            mr[A_FLG] = 8'h04;
            if (cm[i] == 11) begin
                mr[A_WL] = 8'h00;
                mr[A_WH] = 8'h00;
            end else
                `TB_CHK("pin", cp[i][0], pin_q)
            rc(A_FLG);
            `TB_CHK("oe_n", 1'b0, oe_n)
            rc(A_WL);
            rc(A_WH);
        end
        // Capture on every edge selection
        @(posedge clk_i);
        dir_in <= 1'b1;
        repeat (5) @(posedge clk_i);
        for (int i = 0; i < 4; i++) begin
            v = 16'($random(seed));
            wr(A_CCP, 8'h00);
            wr(A_CCP, 8'(4 + i));
            wr(A_WL, v[7:0]);
            wr(A_WH, v[15:8]);
            wr(A_CL, ~v[7:0]);
            wr(A_CH, ~v[15:8]);
            wr(A_FLG, 8'h00);
            src_u.pulse(ne[i] - 1);
            repeat (3) @(posedge clk_i);
            rc(A_CL);
            rc(A_FLG);
            src_u.pulse(1);
            repeat (3) @(posedge clk_i);
            mr[A_CL] = v[7:0];
            mr[A_CH] = v[15:8];
            mr[A_FLG] = 8'h04;
            rc(A_CL);
            rc(A_CH);
            rc(A_FLG);
        end
        // Second capture overwrites an unread one
        wr(A_CCP, 8'h05);
        src_u.pulse(1);
        v = 16'($random(seed));
        wr(A_WL, v[7:0]);
        wr(A_WH, v[15:8]);
        src_u.pulse(1);
        repeat (3) @(posedge clk_i);
        mr[A_CL] = v[7:0];
        mr[A_CH] = v[15:8];
        rc(A_CL);
        rc(A_CH);
        rc(A_FLG);
        rc(A_FLG);
        wr(A_FLG, 8'h00);
        rc(A_FLG);
        wrap_up();
    end
endmodule // tb

// [tccu_chk.sv]
// Port-level assertion checker for the timer/capture/compare unit
`timescale 1ns/1ps
`include "tccu_consts.vh"
module tccu_chk (
    input wire       clk_i,          // Instruction clock
    input wire       nrst_i,         // Reset, active low
    input wire       por_i,          // Reset is power-on
    input wire [7:0] addr_i,         // Register address
    input wire [7:0] wdata_i,        // Write data
    input wire       wr_i,           // Write strobe
    input wire       rd_i,           // Read strobe
    input wire [7:0] rdata_o,        // Read data
    input wire       ccp_pin_o,      // Compare output latch
    input wire       period_match_o, // Match pulse
    input wire       special_trig_o  // Trigger pulse
);
    // ------------
    // Shadow copies of written control values
    // ------------
    reg [7:0] lim_q;  // Period limit
    reg [7:0] ptc_q;  // Period control
    reg [7:0] ccp_q;  // Unit control
    reg [7:0] wc_q;   // Wide timer control
    reg       frd_q;  // Flags were read last cycle
    reg       seen_q; // Event flag seen set since last clear

    // Track writes; reset values as the register table gives them
    always @(posedge clk_i) begin
        frd_q <= rd_i && addr_i == `TCCU_ADR_PERIPHERAL_FLAGS;
        if (!nrst_i) begin
            lim_q  <= `TCCU_RST_PERIOD_LIMIT;
            ptc_q  <= 8'h00;
            ccp_q  <= 8'h00;
            seen_q <= 1'b0;
            if (por_i)
                wc_q <= 8'h00;
        end else if (wr_i) begin
            case (addr_i)
                `TCCU_ADR_PERIOD_LIMIT:     lim_q <= wdata_i;
                `TCCU_ADR_PERIOD_CONTROL:   ptc_q <= wdata_i & 8'h7F;
                `TCCU_ADR_CCP_CONTROL:      ccp_q <= wdata_i & 8'h3F;
                `TCCU_ADR_WIDE_CONTROL:     wc_q <= wdata_i & 8'h3F;
                `TCCU_ADR_PERIPHERAL_FLAGS: seen_q <= 1'b0;
                default: ;
            endcase
        end else if (frd_q && rdata_o[2])
            seen_q <= 1'b1;
    end

    // ------------
    // Sequences and properties
    // ------------
    sequence rd_of(logic [7:0] a);
        rd_i && addr_i == a;
    endsequence
    property rd_gives(logic [7:0] a, logic [7:0] v);
        @(posedge clk_i) disable iff (!nrst_i) rd_of(a) |=> rdata_o == v;
    endproperty

    lim_read_a: assert property (rd_gives(8'h92, lim_q))
        else $error("period limit read wrong");
    ptc_read_a: assert property (rd_gives(8'h12, ptc_q))
        else $error("period control read wrong");
    ccp_read_a: assert property (rd_gives(8'h17, ccp_q))
        else $error("unit control read wrong");
    wctl_read_a: assert property (rd_gives(8'h10, wc_q))
        else $error("wide control read wrong");
    flag_keep_a: assert property (@(posedge clk_i)
        disable iff (!nrst_i) rd_of(8'h0C) ##0 seen_q |=> rdata_o[2])
        else $error("event flag cleared without a write");
    trig_mode_a: assert property (@(posedge clk_i)
        disable iff (!nrst_i) special_trig_o |-> ccp_q[3:0] == 4'hB)
        else $error("trigger outside trigger mode");
    off_low_a: assert property (@(posedge clk_i)
        disable iff (!nrst_i) (ccp_q[3:0] == 4'h0) [*2] |-> !ccp_pin_o)
        else $error("output latch high while unit is off");
    match_on_a: assert property (@(posedge clk_i)
        disable iff (!nrst_i) period_match_o |->
        ptc_q[2] || $past(ptc_q[2]) || $past(ptc_q[2], 2))
        else $error("period match while timer is off");
endmodule // tccu_chk

bind tccu_top tccu_chk chk_u (.clk_i(clk_i), .nrst_i(nrst_i),
    .por_i(por_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .ccp_pin_o(ccp_pin_o),
    .period_match_o(period_match_o), .special_trig_o(special_trig_o));

// [tccu_consts.vh]
// Register offsets, field positions and reset values of the timer/CCP unit
`ifndef TCCU_CONSTS_VH
`define TCCU_CONSTS_VH

// ------------
// Register offsets
// ------------
`define TCCU_ADR_INTERRUPT_CONTROL 8'h0B
`define TCCU_ADR_PERIPHERAL_FLAGS  8'h0C
`define TCCU_ADR_WIDE_LOW          8'h0E
`define TCCU_ADR_WIDE_HIGH         8'h0F
`define TCCU_ADR_WIDE_CONTROL      8'h10
`define TCCU_ADR_PERIOD_COUNT      8'h11
`define TCCU_ADR_PERIOD_CONTROL    8'h12
`define TCCU_ADR_CAPTURE_LOW       8'h15
`define TCCU_ADR_CAPTURE_HIGH      8'h16
`define TCCU_ADR_CCP_CONTROL       8'h17
`define TCCU_ADR_PERIPHERAL_ENABLE 8'h8C
`define TCCU_ADR_PERIOD_LIMIT      8'h92

// ------------
// Field positions
// ------------
`define TCCU_BIT_WIDE_OVF_FLAG     0
`define TCCU_BIT_PERIOD_FLAG       1
`define TCCU_BIT_CCP_FLAG          2
`define TCCU_BIT_WIDE_ON           0
`define TCCU_BIT_PERIOD_ON         2
`define TCCU_PRESCALE_MSB          1
`define TCCU_POSTSCALE_MSB         6
`define TCCU_POSTSCALE_LSB         3
`define TCCU_DUTY_MSB              5
`define TCCU_DUTY_LSB              4
`define TCCU_WIDE_PRE_MSB          5
`define TCCU_WIDE_PRE_LSB          4

// ------------
// Reset values and writable masks
// ------------
`define TCCU_RST_ZERO              8'h00
`define TCCU_RST_PERIOD_LIMIT      8'hFF
`define TCCU_MASK_WIDE_CONTROL     8'h3F
`define TCCU_MASK_PERIOD_CONTROL   8'h7F
`define TCCU_MASK_CCP_CONTROL      8'h3F
`define TCCU_MASK_FLAGS            8'hCF

`endif

// [tccu_pin_src.sv]
// External signal source that drives the capture/compare pin
`timescale 1ns/1ps
module tccu_pin_src (
    input  wire logic clk_i, // Instruction clock
    output logic      pin_o  // Level driven onto the pin
);
    initial pin_o = 1'b0;

    // Full pulses; each level held 3 clocks so edges stay apart
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge clk_i);
            pin_o <= 1'b1;
            repeat (3) @(posedge clk_i);
            pin_o <= 1'b0;
            repeat (2) @(posedge clk_i);
        end
    endtask
endmodule // tccu_pin_src

// [tccu_top.v]
// Timer/capture/compare/PWM unit with its 16-bit and 8-bit timers
`timescale 1ns/1ps
`include "tccu_consts.vh"

// What this block does
// RULE1: Wide timer bytes survive every reset
// RULE2: Wide control zeroed only on power-on
// RULE3: Wide timer byte write clears its prescaler
// RULE4: Period counter readable, writable, reset to zero
// RULE5: Period prescale select 1, 4, 16
// RULE6: Period counter wraps after matching limit
// RULE7: Period limit resets to all ones
// RULE8: Postscaler one to sixteen sets period flag
// RULE9: Period timer runs only when on bit set
// RULE10: Counter or control write clears scalers
// RULE11: Control write keeps period counter value
// RULE12: Pre-postscaler match goes to serial port
// RULE13: PWM uses period timer, others wide
// RULE14: Mode zero disables and resets unit
// RULE15: Capture edge selection from mode field
// RULE16: Compare drives high, low or nothing
// RULE17: Special event trigger resets wide timer
// RULE18: Mode 11xx is PWM with ten-bit duty
// RULE19: Capture copies full wide timer value
// RULE20: Capture sets flag, software clears it
// RULE21: New capture overwrites unread capture
// RULE22: Port write on output pin may capture
// RULE23: Software write beats the special trigger
// RULE24: Special trigger never sets overflow flag
// RULE25: Capture prescaler cleared outside capture mode
// RULE26: Synchronise pin, one event per edge
module tccu_top (
    input  wire       clk_i,           // Instruction clock (osc/4)
    input  wire       nrst_i,          // Synchronous reset, active low
    input  wire       por_i,           // High when the reset is power-on
    input  wire [7:0] addr_i,          // Register address
    input  wire [7:0] wdata_i,         // Write data
    input  wire       wr_i,            // Write strobe
    input  wire       rd_i,            // Read strobe
    output reg  [7:0] rdata_o,         // Read data, cycle after strobe
    input  wire       ccp_pin_i,       // Level seen on the pin
    output wire       ccp_pin_o,       // Compare/PWM output latch
    input  wire       port_dir_in_i,   // Port direction: 1 = input
    output wire       ccp_pin_oe_n_o,  // Low while the unit drives
    output wire       period_match_o,  // Match pulse to serial port
    output wire       special_trig_o   // Special event trigger pulse
);

    // ------------
    // Local definitions
    // ------------
    localparam [3:0] MODE_OFF   = 4'h0;
    localparam [3:0] MODE_FALL  = 4'h4;
    localparam [3:0] MODE_RISE  = 4'h5;
    localparam [3:0] MODE_RISE4 = 4'h6;
    localparam [3:0] MODE_RISE16 = 4'h7;
    localparam [3:0] MODE_SET   = 4'h8;
    localparam [3:0] MODE_CLR   = 4'h9;
    localparam [3:0] MODE_SOFT  = 4'hA;
    localparam [3:0] MODE_TRIG  = 4'hB;

    // Write decode helper
    function wr_hit;
        input [7:0] a;
        input [7:0] r;
        input       w;
        begin
            wr_hit = w && (a == r);
        end
    endfunction

    // ------------
    // Registers
    // ------------
    reg  [7:0] interrupt_control_q;     // Interrupt control, stored only
    reg  [7:0] flags_q;      // Peripheral flags
    reg  [7:0] enables_q;    // Peripheral enables, stored only
    reg  [7:0] wide_lo_q;    // Wide timer low byte
    reg  [7:0] wide_hi_q;    // Wide timer high byte
    reg  [7:0] wide_ctl_q;   // Wide timer control
    reg  [2:0] wide_pre_q;   // Wide timer prescaler counter
    reg  [7:0] per_cnt_q;    // Period timer counter
    reg  [7:0] per_ctl_q;    // Period timer control
    reg  [7:0] per_lim_q;    // Period limit
    reg  [3:0] per_pre_q;    // Period prescaler counter
    reg  [3:0] per_post_q;   // Period postscaler counter
    reg  [7:0] cap_lo_q;     // Capture/compare/duty low byte
    reg  [7:0] cap_hi_q;     // Capture high byte / duty slave
    reg  [1:0] duty_lat_q;   // Latched duty low bits
    reg  [5:0] ccp_ctl_q;    // CCP control
    reg  [3:0] cap_pre_q;    // Capture prescaler counter
    reg        pin_s1_q;     // Synchroniser stage 1
    reg        pin_s2_q;     // Synchroniser stage 2
    reg        pin_s3_q;     // Previous synchronised level
    reg        out_q;        // Compare/PWM output latch
    reg        pm_q;         // Registered period match

    wire [3:0] mode     = ccp_ctl_q[3:0];
    wire       is_cap   = (mode[3:2] == 2'b01);
    wire       is_cmp   = (mode[3:2] == 2'b10);
    wire       is_pwm   = (mode[3:2] == 2'b11);  // RULE18

    wire w_flags = wr_hit(addr_i, `TCCU_ADR_PERIPHERAL_FLAGS, wr_i);
    wire w_wlo   = wr_hit(addr_i, `TCCU_ADR_WIDE_LOW, wr_i);
    wire w_whi   = wr_hit(addr_i, `TCCU_ADR_WIDE_HIGH, wr_i);
    wire w_wctl  = wr_hit(addr_i, `TCCU_ADR_WIDE_CONTROL, wr_i);
    wire w_pcnt  = wr_hit(addr_i, `TCCU_ADR_PERIOD_COUNT, wr_i);
    wire w_pctl  = wr_hit(addr_i, `TCCU_ADR_PERIOD_CONTROL, wr_i);
    wire w_plim  = wr_hit(addr_i, `TCCU_ADR_PERIOD_LIMIT, wr_i);
    wire w_clo   = wr_hit(addr_i, `TCCU_ADR_CAPTURE_LOW, wr_i);
    wire w_chi   = wr_hit(addr_i, `TCCU_ADR_CAPTURE_HIGH, wr_i);
    wire w_cctl  = wr_hit(addr_i, `TCCU_ADR_CCP_CONTROL, wr_i);

    // ------------
    // Wide timer tick and compare
    // ------------
    wire [15:0] wide_val = {wide_hi_q, wide_lo_q};
    wire [2:0]  wide_div = (3'd1 << wide_ctl_q[`TCCU_WIDE_PRE_MSB:
                                               `TCCU_WIDE_PRE_LSB]) - 3'd1;
    wire wide_on   = wide_ctl_q[`TCCU_BIT_WIDE_ON];
    wire wide_tick = wide_on && (wide_pre_q >= wide_div);
    wire [15:0] wide_nxt = wide_val + 16'h0001;
    wire wide_ovf  = wide_tick && (wide_val == 16'hFFFF);
    wire cmp_match = is_cmp && (wide_val == {cap_hi_q, cap_lo_q}) &&
                     !(w_wlo || w_whi);
    wire trig      = cmp_match && (mode == MODE_TRIG);  // RULE17
    assign special_trig_o = trig;

    // ------------
    // Period timer tick
    // ------------
    wire       per_on   = per_ctl_q[`TCCU_BIT_PERIOD_ON];  // RULE9
    wire [3:0] per_div  = per_ctl_q[`TCCU_PRESCALE_MSB] ? 4'hF :
                          (per_ctl_q[0] ? 4'h3 : 4'h0);  // RULE5
    wire       per_tick = per_on && (per_pre_q >= per_div);
    wire       per_hit  = per_tick && (per_cnt_q == per_lim_q);  // RULE6
    wire [3:0] post_sel = per_ctl_q[`TCCU_POSTSCALE_MSB:
                                    `TCCU_POSTSCALE_LSB];
    wire       post_out = per_hit && (per_post_q >= post_sel);  // RULE8
    assign period_match_o = pm_q;  // RULE12

    // ------------
    // Capture event detection
    // ------------
    // Pin value as seen by the unit; output pin reflects its own latch
    wire pin_rise = pin_s2_q && !pin_s3_q;  // RULE26
    wire pin_fall = !pin_s2_q && pin_s3_q;
    reg  cap_evt;
    always @* begin
        cap_evt = 1'b0;
        case (mode)
            MODE_FALL:   cap_evt = pin_fall;  // RULE15
            MODE_RISE:   cap_evt = pin_rise;
            MODE_RISE4:  cap_evt = pin_rise && (cap_pre_q[1:0] == 2'h3);
            MODE_RISE16: cap_evt = pin_rise && (cap_pre_q == 4'hF);
            default:     cap_evt = 1'b0;
        endcase
    end

    // PWM duty compare: 10-bit duty against counter and prescale phase
    wire [9:0] pwm_pos = {per_cnt_q, per_pre_q[3:2]};
    wire [9:0] pwm_dut = {cap_hi_q, duty_lat_q};

    // ------------
    // Pin synchroniser and output drive
    // ------------
    // Port write to an output pin shows on the input path too
    wire pin_seen = port_dir_in_i ? ccp_pin_i : out_q;  // RULE22
    always @(posedge clk_i) begin
        if (!nrst_i) begin
            pin_s1_q <= 1'b0;
            pin_s2_q <= 1'b0;
            pin_s3_q <= 1'b0;
        end else begin
            pin_s1_q <= pin_seen;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end
    assign ccp_pin_o      = out_q;
    assign ccp_pin_oe_n_o = port_dir_in_i;

    // ------------
    // Wide timer: no reset on its bytes, trigger clears them
    // ------------
    always @(posedge clk_i) begin
        if (w_wlo) begin
            wide_lo_q <= wdata_i;  // RULE23
        end else if (trig) begin
            wide_lo_q <= 8'h00;  // RULE1
        end else if (nrst_i && wide_tick) begin
            wide_lo_q <= wide_nxt[7:0];
        end
        if (w_whi) begin
            wide_hi_q <= wdata_i;  // RULE23
        end else if (trig) begin
            wide_hi_q <= 8'h00;  // RULE1
        end else if (nrst_i && wide_tick) begin
            wide_hi_q <= wide_nxt[15:8];
        end
    end

    // Wide control and prescaler
    always @(posedge clk_i) begin
        if (!nrst_i) begin
            if (por_i) begin
                wide_ctl_q <= `TCCU_RST_ZERO;  // RULE2
            end
            wide_pre_q <= 3'd0;
        end else begin
            if (w_wctl) begin
                wide_ctl_q <= wdata_i & `TCCU_MASK_WIDE_CONTROL;
            end
            if (w_wlo || w_whi || trig || wide_tick) begin
                wide_pre_q <= 3'd0;  // RULE3
            end else if (wide_on) begin
                wide_pre_q <= wide_pre_q + 3'd1;
            end
        end
    end

    // ------------
    // Period timer
    // ------------
    always @(posedge clk_i) begin
        if (!nrst_i) begin
            per_cnt_q  <= `TCCU_RST_ZERO;  // RULE4
            per_ctl_q  <= `TCCU_RST_ZERO;
            per_lim_q  <= `TCCU_RST_PERIOD_LIMIT;  // RULE7
            per_pre_q  <= 4'h0;  // RULE10
            per_post_q <= 4'h0;
            pm_q       <= 1'b0;
        end else begin
            pm_q <= per_hit;
            if (w_plim) begin
                per_lim_q <= wdata_i;
            end
            if (w_pctl) begin
                per_ctl_q <= wdata_i & `TCCU_MASK_PERIOD_CONTROL;
            end
            if (w_pcnt) begin
                per_cnt_q <= wdata_i;
            end else if (per_hit) begin
                per_cnt_q <= 8'h00;  // RULE6
            end else if (per_tick) begin
                per_cnt_q <= per_cnt_q + 8'h01;
            end  // RULE11
            if (w_pcnt || w_pctl) begin
                per_pre_q  <= 4'h0;  // RULE10
                per_post_q <= 4'h0;
            end else begin
                if (per_tick) begin
                    per_pre_q <= 4'h0;
                end else if (per_on) begin
                    per_pre_q <= per_pre_q + 4'h1;
                end
                if (post_out) begin
                    per_post_q <= 4'h0;
                end else if (per_hit) begin
                    per_post_q <= per_post_q + 4'h1;
                end
            end
        end
    end

    // ------------
    // CCP control, capture register, output latch
    // ------------
    always @(posedge clk_i) begin
        if (!nrst_i) begin
            ccp_ctl_q  <= 6'h00;
            cap_pre_q  <= 4'h0;
            out_q      <= 1'b0;
            duty_lat_q <= 2'h0;
        end else begin
            if (w_cctl) begin
                ccp_ctl_q <= wdata_i[5:0];
            end
            if (!is_cap) begin
                cap_pre_q <= 4'h0;  // RULE25
            end else if (pin_rise) begin
                cap_pre_q <= cap_pre_q + 4'h1;
            end
            if (mode == MODE_OFF) begin
                out_q <= 1'b0;  // RULE14
            end else if (cmp_match && mode == MODE_SET) begin
                out_q <= 1'b1;  // RULE16
            end else if (cmp_match && mode == MODE_CLR) begin
                out_q <= 1'b0;  // RULE16
            end else if (is_pwm) begin  // RULE13
                if (per_hit) begin
                    out_q <= (pwm_dut != 10'h000) ? 1'b1 : 1'b0;
                end else if (pwm_pos == pwm_dut) begin
                    out_q <= 1'b0;
                end
            end
            if (is_pwm && per_hit) begin
                duty_lat_q <= ccp_ctl_q[`TCCU_DUTY_MSB:`TCCU_DUTY_LSB];
            end
        end
    end

    // Capture value bytes: not reset, loaded by software or events
    always @(posedge clk_i) begin
        if (nrst_i && is_cap && cap_evt) begin
            cap_lo_q <= wide_val[7:0];  // RULE19 RULE21
            cap_hi_q <= wide_val[15:8];
        end else begin
            if (w_clo) begin
                cap_lo_q <= wdata_i;
            end
            if (nrst_i && is_pwm && per_hit) begin
                cap_hi_q <= cap_lo_q;  // RULE18
            end else if (w_chi && !is_pwm) begin
                cap_hi_q <= wdata_i;
            end
        end
    end

    // ------------
    // Flags, enables and interrupt control; set beats clear
    // ------------
    wire ccp_set = (is_cap && cap_evt) || cmp_match;  // RULE20 RULE16
    always @(posedge clk_i) begin
        if (!nrst_i) begin
            flags_q   <= `TCCU_RST_ZERO;
            enables_q <= `TCCU_RST_ZERO;
            interrupt_control_q  <= `TCCU_RST_ZERO;
        end else begin
            if (wr_hit(addr_i, `TCCU_ADR_PERIPHERAL_ENABLE, wr_i)) begin
                enables_q <= wdata_i & `TCCU_MASK_FLAGS;
            end
            if (wr_hit(addr_i, `TCCU_ADR_INTERRUPT_CONTROL, wr_i)) begin
                interrupt_control_q <= wdata_i;
            end
            flags_q <= (w_flags ? (wdata_i & `TCCU_MASK_FLAGS) : flags_q)
                     | {5'h00, ccp_set, post_out,
                        wide_ovf && !trig};  // RULE24 RULE8
        end
    end

    // ------------
    // Read port: data one cycle after the strobe
    // ------------
    always @(posedge clk_i) begin
        if (!nrst_i) begin
            rdata_o <= 8'h00;
        end else if (!rd_i) begin
            rdata_o <= 8'h00;
        end else if (addr_i == `TCCU_ADR_INTERRUPT_CONTROL) begin
            rdata_o <= interrupt_control_q;
        end else if (addr_i == `TCCU_ADR_PERIPHERAL_FLAGS) begin
            rdata_o <= flags_q;
        end else if (addr_i == `TCCU_ADR_WIDE_LOW) begin
            rdata_o <= wide_lo_q;
        end else if (addr_i == `TCCU_ADR_WIDE_HIGH) begin
            rdata_o <= wide_hi_q;
        end else if (addr_i == `TCCU_ADR_WIDE_CONTROL) begin
            rdata_o <= wide_ctl_q;
        end else if (addr_i == `TCCU_ADR_PERIOD_COUNT) begin
            rdata_o <= per_cnt_q;
        end else if (addr_i == `TCCU_ADR_PERIOD_CONTROL) begin
            rdata_o <= per_ctl_q;
        end else if (addr_i == `TCCU_ADR_CAPTURE_LOW) begin
            rdata_o <= cap_lo_q;
        end else if (addr_i == `TCCU_ADR_CAPTURE_HIGH) begin
            rdata_o <= cap_hi_q;
        end else if (addr_i == `TCCU_ADR_CCP_CONTROL) begin
            rdata_o <= {2'b00, ccp_ctl_q};
        end else if (addr_i == `TCCU_ADR_PERIPHERAL_ENABLE) begin
            rdata_o <= enables_q;
        end else if (addr_i == `TCCU_ADR_PERIOD_LIMIT) begin
            rdata_o <= per_lim_q;
        end else begin
            rdata_o <= 8'h00;
        end
    end

endmodule // tccu_top
